/* File: hdl/mpt_defines.vh */
`ifndef MPT_DEFINES_VH
`define MPT_DEFINES_VH
// Register byte offsets
`define MPT_OFF_STAT    8'h00
`define MPT_OFF_MASK    8'h04
`define MPT_OFF_CTRL    8'h08
`define MPT_OFF_COUNT   8'h0c
`define MPT_OFF_PRESC   8'h10
`define MPT_OFF_PCNT    8'h14
`define MPT_OFF_MCTRL   8'h18
`define MPT_OFF_PCTRL   8'h1c
`define MPT_OFF_LATCH   8'h20
`define MPT_OFF_CAPSEL  8'h24
`define MPT_OFF_MATCH0  8'h40
// Control field positions
`define MPT_CTRL_RUN    0
`define MPT_CTRL_CLR    1
`define MPT_CTRL_PWM    2
`define MPT_CTRL_CNTM   3
// Match control: three bits per channel
`define MPT_MC_INT      0
`define MPT_MC_RST      1
`define MPT_MC_STOP     2
// Reset values
`define MPT_RST_ZERO    32'h00000000
`define MPT_NUM_MATCH   7
`endif

/* File: hdl/mpt_pwm.v */
//Function
// - 32-bit counter with 32-bit prescaler
// - Timer on pclk, counter on capture edges
// - Seven match registers, six outputs
// - Cycle match resets counter, sets period
// - Single-edge: high at cycle start, fall
// - Double-edge: rise and fall matches anywhere
// - Outputs share cycle match repetition rate
// - Per-match continue, stop, reset, interrupt
// - Shadowed match values applied at cycle
// - Period and width any count value
// - PWM disabled gives plain timer only
`timescale 1ns/1ps
`include "mpt_defines.vh"
`default_nettype none
module mpt_pwm
(
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [1:0]  capIn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [6:1]  pwmOut,
  output reg         irq
);
  ////////////////////////////////////////////////////////////////////////
  // Storage
  reg  [31:0] ctrl;                 // Run, clear, pwm enable, count mode
  reg  [31:0] count;                // Timer count
  reg  [31:0] presc;                // Prescale limit
  reg  [31:0] pcnt;                 // Prescale count
  reg  [20:0] mctrl;                // Per-match actions
  reg  [12:0] pctrl;                // Double-edge sel [6:2], enables [12:7]
  reg  [6:0]  latchEn;              // Released shadow values
  reg  [1:0]  capSel;               // [0] input select, [1] falling edge
  reg  [6:0]  stat;                 // Sticky match flags
  reg  [6:0]  mask;                 // Interrupt enables
  reg  [31:0] shadow [0:6];         // Software-written match values
  reg  [31:0] active [0:6];         // Values the comparators use
  reg  [7:0]  awAddr;               // Captured write address
  reg  [31:0] wData;                // Captured write data
  reg  [3:0]  wStrb;                // Captured strobes
  reg         awHave;               // Address held
  reg         wHave;                // Data held
  reg         capPrev;              // Previous synced capture level
  wire [1:0]  capLvl;               // Synchronised capture inputs
  integer     i;                    // Loop index, register process only
  integer     cmpIdx;               // Loop index, match compare
  integer     outIdx;               // Loop index, pulse outputs

  ////////////////////////////////////////////////////////////////////////
  // Byte-lane merge used by register writes other than STAT, LATCH and CAPSEL
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        merge[k*8 +: 8] = st[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
    end
  endfunction

  // Match index of an address, 7 when not a match register
  function [2:0] matchIdx;
    input [7:0] a;
    begin
      if (a >= `MPT_OFF_MATCH0 && a < `MPT_OFF_MATCH0 + 8'h1c && a[1:0] == 2'b00)
        matchIdx = a[4:2];
      else
        matchIdx = 3'h7;
    end
  endfunction

  // Capture pins pass the three-flop synchroniser
  mpt_sync uSync0 (.clk(clk), .sys_rst(sys_rst), .pinIn(capIn[0]), .level(capLvl[0]));
  mpt_sync uSync1 (.clk(clk), .sys_rst(sys_rst), .pinIn(capIn[1]), .level(capLvl[1]));

  ////////////////////////////////////////////////////////////////////////
  // Count engine
  wire capNow  = capSel[0] ? capLvl[1] : capLvl[0];
  wire capEdge = capSel[1] ? (capPrev & ~capNow) : (~capPrev & capNow);
  wire tickSrc = ctrl[`MPT_CTRL_CNTM] ? capEdge : 1'b1;
  wire run     = ctrl[`MPT_CTRL_RUN] & ~ctrl[`MPT_CTRL_CLR];
  wire tick    = run & tickSrc & (pcnt == presc);
  reg  [6:0]  hit;                  // Matches seen at this tick
  reg         doRst;                // Some match asks reset
  reg         doStop;               // Some match asks stop
  // Match compare against live value
  always @*
  begin
    doRst  = 1'b0;
    doStop = 1'b0;
    for (cmpIdx = 0; cmpIdx < 7; cmpIdx = cmpIdx + 1)
    begin
      hit[cmpIdx] = tick & (count == active[cmpIdx]);
      if (hit[cmpIdx] & mctrl[cmpIdx*3+`MPT_MC_RST])
        doRst = 1'b1;
      if (hit[cmpIdx] & mctrl[cmpIdx*3+`MPT_MC_STOP])
        doStop = 1'b1;
    end
    // Cycle match always closes the period in pwm mode
    if (hit[0] & ctrl[`MPT_CTRL_PWM])
      doRst = 1'b1;
  end
  wire cycEnd = hit[0] & doRst;     // Start of new cycle

  ////////////////////////////////////////////////////////////////////////
  // AXI write path decode
  wire        wrGo   = awHave & wHave & ~s_axi_bvalid;
  wire [2:0]  wrIdx  = matchIdx(awAddr);
  wire [31:0] maskMrg  = merge({25'h0, mask}, wData, wStrb);  // Merged mask write
  wire [31:0] mctrlMrg = merge({11'h0, mctrl}, wData, wStrb); // Merged match control
  wire [31:0] pctrlMrg = merge({19'h0, pctrl}, wData, wStrb); // Merged output control
  reg         wrOk;                 // Address maps to a register
  always @*
  begin
    case (awAddr)
      `MPT_OFF_STAT, `MPT_OFF_MASK, `MPT_OFF_CTRL, `MPT_OFF_COUNT,
      `MPT_OFF_PRESC, `MPT_OFF_PCNT, `MPT_OFF_MCTRL, `MPT_OFF_PCTRL,
      `MPT_OFF_LATCH, `MPT_OFF_CAPSEL: wrOk = 1'b1;
      default: wrOk = (wrIdx != 3'h7);
    endcase
  end

  // Registers, counter and bus write
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl <= `MPT_RST_ZERO;
      count <= `MPT_RST_ZERO;
      presc <= `MPT_RST_ZERO;
      pcnt <= `MPT_RST_ZERO;
      mctrl <= 21'h000000;
      pctrl <= 13'h0000;
      latchEn <= 7'h00;
      capSel <= 2'h0;
      stat <= 7'h00;
      mask <= 7'h00;
      capPrev <= 1'b0;
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      for (i = 0; i < 7; i = i + 1)
      begin
        shadow[i] <= `MPT_RST_ZERO;
        active[i] <= `MPT_RST_ZERO;
      end
    end
    else
    begin
      capPrev <= capNow;
      // Prescaler and counter
      if (ctrl[`MPT_CTRL_CLR])
      begin
        pcnt <= `MPT_RST_ZERO;
        count <= `MPT_RST_ZERO;
      end
      else if (run & tickSrc)
      begin
        pcnt <= (pcnt == presc) ? `MPT_RST_ZERO : pcnt + 32'h00000001;
        if (tick)
          count <= doRst ? `MPT_RST_ZERO : count + 32'h00000001;
      end
      if (doStop)
        ctrl[`MPT_CTRL_RUN] <= 1'b0;
      // Released shadows move over at cycle start in pwm mode; all move every clock otherwise
      if (cycEnd | ~ctrl[`MPT_CTRL_PWM])
      begin
        for (i = 0; i < 7; i = i + 1)
          if (latchEn[i] | ~ctrl[`MPT_CTRL_PWM])
            active[i] <= shadow[i];
        if (ctrl[`MPT_CTRL_PWM])
          latchEn <= 7'h00;
      end
      // AXI address and data capture, either order
      s_axi_awready <= ~awHave & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~wHave & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        awHave <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        wHave <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // Sticky flags; later clear yields to new set below
      if (wrGo)
      begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? 2'h0 : 2'h2;                              // Unmapped: SLVERR
        case (awAddr)
          `MPT_OFF_STAT:   stat <= stat & ~wData[6:0];
          `MPT_OFF_MASK:   mask <= maskMrg[6:0];
          `MPT_OFF_CTRL:   ctrl <= merge(ctrl, wData, wStrb) & 32'h0000000f;
          `MPT_OFF_COUNT:  count <= merge(count, wData, wStrb);
          `MPT_OFF_PRESC:  presc <= merge(presc, wData, wStrb);
          `MPT_OFF_PCNT:   pcnt <= merge(pcnt, wData, wStrb);
          `MPT_OFF_MCTRL:  mctrl <= mctrlMrg[20:0];
          `MPT_OFF_PCTRL:  pctrl <= pctrlMrg[12:0] & 13'h1ffc;
          `MPT_OFF_LATCH:  latchEn <= latchEn | wData[6:0];
          `MPT_OFF_CAPSEL: capSel <= wData[1:0];
          default:
            if (wrIdx != 3'h7)
              shadow[wrIdx] <= merge(shadow[wrIdx], wData, wStrb);
        endcase
      end
      for (i = 0; i < 7; i = i + 1)
        if (hit[i] & mctrl[i*3+`MPT_MC_INT])
          stat[i] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pulse outputs, all timed off the same cycle match
  reg [6:1] next_pwmOut;
  always @*
  begin
    next_pwmOut = pwmOut;
    for (outIdx = 1; outIdx < 7; outIdx = outIdx + 1)
    begin
      if (outIdx >= 2 && pctrl[outIdx])
      begin
        // Double-edge: rise on match n-1, fall on match n
        if (hit[outIdx-1])
          next_pwmOut[outIdx] = 1'b1;
        if (hit[outIdx])
          next_pwmOut[outIdx] = 1'b0;
      end
      else
      begin
        if (cycEnd)
          next_pwmOut[outIdx] = 1'b1;
        if (hit[outIdx])
          next_pwmOut[outIdx] = 1'b0;
      end
      if (!pctrl[outIdx+6] || !ctrl[`MPT_CTRL_PWM])
        next_pwmOut[outIdx] = 1'b0;
    end
  end

  // Output and interrupt flops
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      pwmOut <= 6'h00;
      irq <= 1'b0;
    end
    else
    begin
      pwmOut <= next_pwmOut;
      irq <= |(stat & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI read path, one-cycle answer after address taken
  reg [31:0] rdVal;                 // Read mux
  reg        rdOk;                  // Address maps
  wire [2:0] rdIdx = matchIdx(s_axi_araddr);
  always @*
  begin
    rdOk = 1'b1;
    case (s_axi_araddr)
      `MPT_OFF_STAT:   rdVal = {25'h0, stat};
      `MPT_OFF_MASK:   rdVal = {25'h0, mask};
      `MPT_OFF_CTRL:   rdVal = ctrl;
      `MPT_OFF_COUNT:  rdVal = count;
      `MPT_OFF_PRESC:  rdVal = presc;
      `MPT_OFF_PCNT:   rdVal = pcnt;
      `MPT_OFF_MCTRL:  rdVal = {11'h0, mctrl};
      `MPT_OFF_PCTRL:  rdVal = {19'h0, pctrl};
      `MPT_OFF_LATCH:  rdVal = {25'h0, latchEn};
      `MPT_OFF_CAPSEL: rdVal = {30'h0, capSel};
      default:
      begin
        rdVal = (rdIdx != 3'h7) ? shadow[rdIdx] : 32'h00000000;
        rdOk = (rdIdx != 3'h7);
      end
    endcase
  end

  // Read handshake
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdVal;
        s_axi_rresp <= rdOk ? 2'h0 : 2'h2;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // mpt_pwm
`default_nettype wire

/* File: hdl/mpt_sync.v */
`timescale 1ns/1ps
`default_nettype none
// Three-stage input synchroniser, change accepted when stages 2 and 3 agree
module mpt_sync
(
  input  wire clk,
  input  wire sys_rst,
  input  wire pinIn,
  output reg  level
);
  reg stage1; // Metastability catcher, read only by stage2
  reg stage2;
  reg stage3;

  // Shift chain and agreement filter
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level  <= 1'b0;
    end
    else
    begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        level <= stage3;
    end
  end
endmodule // mpt_sync
`default_nettype wire

/* File: testbench/mpt_load_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Load on each output: measures last high time and period in clocks
module mpt_load_model
(
  input wire logic       clk,
  input wire logic [6:1] pwmOut
);
  int         hi  [1:6] = '{default: 0}; // Last high length
  int         per [1:6] = '{default: 0}; // Last rise-to-rise period
  int         age [1:6] = '{default: 0}; // Clocks since last rise
  logic [6:1] last      = 6'h00;         // Previous sample
  // One counter per output serves both measures
  always @(posedge clk)
  begin
    for (int i = 1; i <= 6; i++)
    begin
      if (pwmOut[i] && !last[i])
      begin
        per[i] = age[i];
        age[i] = 0;
      end
      if (!pwmOut[i] && last[i])
        hi[i] = age[i];
      age[i] = age[i] + 1;
    end
    last = pwmOut;
  end
endmodule // mpt_load_model
`default_nettype wire

/* File: testbench/mpt_pwm_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the bus handshake and outputs of the pulse timer
module mpt_pwm_checker
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [6:1] pwmOut,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  // Answers stand until the master takes them
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped early");
  // Only one answer per request, since one is outstanding
  bdone_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  rdone_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  // Ready strobes are single pulses
  awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready held");
  wready_pulse_a: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("data ready held");
  // Read answer comes one cycle after the address is taken
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Only okay or slave error are produced
  bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp[0] == 1'b0)
    else $error("illegal write response");
  // Outputs quiet when reset lets go
  reset_quiet_a: assert property ($fell(sys_rst) |-> pwmOut == 6'h00 && !irq)
    else $error("outputs active after reset");
  cover property ($rose(irq));
  cover property ($rose(pwmOut[1]));
  cover property ($rose(pwmOut[2]));
endmodule // mpt_pwm_checker
bind mpt_pwm mpt_pwm_checker chk
(
  .clk           (clk),
  .sys_rst       (sys_rst),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_awready (s_axi_awready),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .pwmOut        (pwmOut),
  .irq           (irq)
);
`default_nettype wire

/* File: testbench/tb_multi_output_pwm_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mpt_defines.vh"
module tb_multi_output_pwm_timer;
  logic        clk, sys_rst, irq;
  logic [1:0]  capIn, s_axi_bresp, s_axi_rresp, resp;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, got, held;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [6:1]  pwmOut;
  integer      fails, checks_done;
  mpt_pwm uut
  (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .capIn         (capIn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .pwmOut        (pwmOut),
    .irq           (irq)
  );
  mpt_load_model load (.clk(clk), .pwmOut(pwmOut));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  // A hang counts against the run
  task hang(input integer n);
  begin
    if (n > 100)
    begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  end
  endtask
  // Bus write: valids released as each ready is seen
  task wr(input logic [7:0] a, input logic [31:0] d);
    integer n;
  begin
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      n = n + 1;
      hang(n);
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  end
  endtask
  // Bus read: data and response taken at the answering edge
  task rd(input logic [7:0] a);
    integer n;
  begin
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      n = n + 1;
      hang(n);
    end while (!s_axi_rvalid);
    got = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    fails = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    capIn = 2'b00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(irq, 1'b0);
    rd(`MPT_OFF_COUNT);
    chk(got, 32'h0);
    // Period of ten counts, single edge on 1, double edge on 2
    wr(`MPT_OFF_PRESC, 32'h0);
    wr(`MPT_OFF_MATCH0, 32'h9);
    wr(`MPT_OFF_MATCH0 + 8'h04, 32'h3);
    wr(`MPT_OFF_MATCH0 + 8'h08, 32'h7);
    wr(`MPT_OFF_LATCH, 32'h7f);
    wr(`MPT_OFF_PCTRL, 32'h184);
    wr(`MPT_OFF_CTRL, 32'h5);
    repeat (40) @(posedge clk);
    chk(load.per[1], 10);
    chk(load.per[2], 10);
    chk(load.hi[1], 4);
    chk(load.hi[2], 4);
    // New width waits for release
    wr(`MPT_OFF_MATCH0 + 8'h04, 32'h5);
    repeat (30) @(posedge clk);
    chk(load.hi[1], 4);
    chk(load.hi[2], 4);
    wr(`MPT_OFF_LATCH, 32'h2);
    repeat (30) @(posedge clk);
    chk(load.hi[1], 6);
    chk(load.hi[2], 2);
    // Cycle match flag, masked then unmasked then cleared
    wr(`MPT_OFF_MCTRL, 32'h1);
    repeat (20) @(posedge clk);
    chk(irq, 1'b0);
    rd(`MPT_OFF_STAT);
    chk(got, 32'h1);
    wr(`MPT_OFF_MASK, 32'h1);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wr(`MPT_OFF_MCTRL, 32'h0);
    wr(`MPT_OFF_STAT, 32'h1);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    // Plain timer, match 2 resets the count
    wr(`MPT_OFF_CTRL, 32'h2);
    wr(`MPT_OFF_MCTRL, 32'h80);
    wr(`MPT_OFF_CTRL, 32'h1);
    repeat (3)
    begin
      rd(`MPT_OFF_COUNT);
      chk({31'h0, got < 32'h8}, 32'h1);
      chk(pwmOut, 6'h00);
    end
    // Match 1 stops the timer; count then holds
    wr(`MPT_OFF_CTRL, 32'h2);
    wr(`MPT_OFF_MCTRL, 32'h20);
    wr(`MPT_OFF_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    rd(`MPT_OFF_CTRL);
    chk(got, 32'h0);
    rd(`MPT_OFF_COUNT);
    held = got;
    repeat (10) @(posedge clk);
    rd(`MPT_OFF_COUNT);
    chk(got, held);
    chk({31'h0, got > 32'h4}, 32'h1);
    rd(8'hfc);
    chk(resp, 2'b10);
    // Count rising edges of the first capture pin
    wr(`MPT_OFF_MCTRL, 32'h0);
    wr(`MPT_OFF_CTRL, 32'h2);
    wr(`MPT_OFF_CAPSEL, 32'h0);
    wr(`MPT_OFF_CTRL, 32'h9);
    repeat (5)
    begin
      capIn <= 2'b01;
      repeat (8) @(posedge clk);
      capIn <= 2'b00;
      repeat (8) @(posedge clk);
    end
    rd(`MPT_OFF_COUNT);
    chk(got, 32'h5);
    // Falling edges of the second capture pin
    wr(`MPT_OFF_CAPSEL, 32'h3);
    repeat (3)
    begin
      capIn <= 2'b10;
      repeat (8) @(posedge clk);
      capIn <= 2'b00;
      repeat (8) @(posedge clk);
    end
    rd(`MPT_OFF_COUNT);
    chk(got, 32'h8);
    report_and_stop;
  end
endmodule // tb_multi_output_pwm_timer
`default_nettype wire
